// ==== src/cbsck_consts.svh ====
// constants shared by both ends of the card slot clock and reset link
`ifndef CBSCK_CONSTS_SVH
`define CBSCK_CONSTS_SVH

// width of the shared address/data bus
`define CBSCK_AD_W 32
// width of the internal cycle counters
`define CBSCK_CNT_W 8
// master clock cycles of notice before a slowdown takes effect
`define CBSCK_NOTICE_CYC 8
// in the slowed mode one card clock pulse every this many master cycles
`define CBSCK_SLOW_DIV 4
// flip-flops in each pin synchroniser
`define CBSCK_SYNC_STAGES 2

// clock state encodings, gray in the order run, notice, slow, stop
`define CBSCK_ST_RUN 3'h0
`define CBSCK_ST_NOTICE 3'h1
`define CBSCK_ST_SLOW 3'h3
`define CBSCK_ST_STOP 3'h2

// reset values
`define CBSCK_RST_CLK_EN 1'h1
`define CBSCK_RST_AD 32'h0000_0000
`define CBSCK_RST_AD_OE 1'h1

`endif

// ==== src/cbsck_pkg.sv ====
// types shared by both ends of the card slot clock and reset link
`include "cbsck_consts.svh"

package cbsck_pkg;

  // clock control states of the socket
  typedef enum logic [2:0] {
    CBSCK_RUN    = `CBSCK_ST_RUN,
    CBSCK_NOTICE = `CBSCK_ST_NOTICE,
    CBSCK_SLOW   = `CBSCK_ST_SLOW,
    CBSCK_STOP   = `CBSCK_ST_STOP
  } cbsck_clk_state_e;

  // counter type
  typedef logic [`CBSCK_CNT_W-1:0] cbsck_cnt_t;

endpackage

// ==== src/cbsck_if.sv ====
// interface joining the socket end and the card end of the slot
`timescale 1ns/1ps
`include "cbsck_consts.svh"

interface cbsck_if #(
  parameter int AD_W = `CBSCK_AD_W
);
  // clock and reset, driven by the socket
  logic            card_clock;
  logic            card_reset_n;
  // clock run line, open drain, pulled high when nobody drives
  logic            run_sock_oe;
  logic            run_card_oe;
  logic            card_clock_run_request_n;
  // card interrupt line, open drain from the card
  logic            int_card_oe;
  logic            card_interrupt_n;
  // shared address/data bus
  logic [AD_W-1:0] ad_sock_o;
  logic            ad_sock_oe;
  logic [AD_W-1:0] ad_card_o;
  logic            ad_card_oe;
  logic [AD_W-1:0] ad;

  // wire levels worked out from the enables
  assign card_clock_run_request_n = ~(run_sock_oe | run_card_oe);
  assign card_interrupt_n         = ~int_card_oe;
  assign ad = ad_sock_oe ? ad_sock_o : (ad_card_oe ? ad_card_o : '0);

  // socket end
  modport socket (
    output card_clock,
    output card_reset_n,
    output run_sock_oe,
    output ad_sock_o,
    output ad_sock_oe,
    input  card_clock_run_request_n,
    input  card_interrupt_n,
    input  ad
  );

  // card end
  modport card (
    input  card_clock,
    input  card_reset_n,
    input  card_clock_run_request_n,
    input  ad,
    output run_card_oe,
    output int_card_oe,
    output ad_card_o,
    output ad_card_oe
  );
endinterface

// ==== src/cbsck_socket.sv ====
// socket end: card clock generation, clock run handshake and card reset
`timescale 1ns/1ps
`include "cbsck_consts.svh"

// Summary of operation
// [R01] socket drives card clock for all transfers
// [R02] card bus sampled on rising card clock
// [R03] normal card clock equals master clock rate
// [R04] slow or stop clock, stopped means low
// [R05] card pulls clock run to restart clock
// [R06] socket releases clock run before slowing down
// [R07] card reset returns everything to known state
// [R08] in reset card floats, socket drives lines
// [R09] card reset asserts at any moment
// [R10] card reset releases on card clock edge
// [R11] glitch free gating, full phases only
// [R12] address/data bus is 32 bits wide
module cbsck_socket #(
  parameter int AD_W       = `CBSCK_AD_W,       // bus width
  parameter int NOTICE_CYC = `CBSCK_NOTICE_CYC, // notice length in master cycles
  parameter int SLOW_DIV   = `CBSCK_SLOW_DIV    // slowed clock divider
) (
  // master clock and reset
  input  wire logic                  I_MCLK,
  input  wire logic                  I_ARST_N,
  // user control
  input  wire logic                  I_CARD_RESET_REQ,
  input  wire logic                  I_SLOW_REQ,
  input  wire logic                  I_STOP_REQ,
  // user data toward the card
  input  wire logic [AD_W-1:0]       I_AD_OUT,
  input  wire logic                  I_AD_OE,
  // user status and data from the card
  output logic                       O_CARD_IN_RESET,
  output logic [AD_W-1:0]            O_AD_IN,
  output logic                       O_AD_VALID,
  output logic                       O_CARD_INTERRUPT,
  output cbsck_pkg::cbsck_clk_state_e O_CLK_STATE,
  // link to the card
  cbsck_if.socket                    LINK
);

  // counter limits at counter width
  localparam cbsck_pkg::cbsck_cnt_t NOTICE_LAST =
    cbsck_pkg::cbsck_cnt_t'(NOTICE_CYC - 1);
  localparam cbsck_pkg::cbsck_cnt_t SLOW_LAST =
    cbsck_pkg::cbsck_cnt_t'(SLOW_DIV - 1);
  // own release of the clock run line needs this long to show at the synchroniser
  localparam cbsck_pkg::cbsck_cnt_t SETTLE =
    cbsck_pkg::cbsck_cnt_t'(`CBSCK_SYNC_STAGES + 1);

  // state and counters
  cbsck_pkg::cbsck_clk_state_e state;      // clock control state
  cbsck_pkg::cbsck_clk_state_e next_state; // next clock control state
  cbsck_pkg::cbsck_cnt_t       notice_cnt; // cycles spent in notice
  cbsck_pkg::cbsck_cnt_t       slow_cnt;   // divider position in slowed mode

  // reset release chain
  logic rst_req_n; // combined asynchronous reset request, active low
  logic rst_q1;    // first release stage
  logic rst_q2;    // released card reset level

  // clock gate
  logic gate_req; // wanted gate value, settled before the falling edge
  logic clk_en;   // gate enable, changes only while the master clock is low

  // pin synchronisers
  logic run_s1; // clock run, first stage
  logic run_s2; // clock run, usable level
  logic int_s1; // card interrupt, first stage
  logic int_s2; // card interrupt, usable level

  // decoded conditions
  logic card_up;     // card reset released
  logic listen;      // own release has reached the synchroniser
  logic card_wants;  // card holds the clock run line low
  logic notice_done; // notice period over

  // bus drive registers
  logic [AD_W-1:0] ad_o;  // value driven on the bus
  logic            ad_oe; // bus drive enable

  // reset assertion is combinational so it needs no clock at all
  assign rst_req_n = I_ARST_N & ~I_CARD_RESET_REQ; // R09

  // release chain on the master clock; the clock gate is forced open during
  // reset, so the release edge coincides with a card clock rising edge
  always_ff @(posedge I_MCLK or negedge rst_req_n) begin
    if (!rst_req_n) begin
      rst_q1 <= 1'h0;
      rst_q2 <= 1'h0;
    end else begin
      rst_q1 <= 1'h1;
      rst_q2 <= rst_q1; // R10
    end
  end

  // clock run synchroniser, the line is asynchronous to the master clock
  always_ff @(posedge I_MCLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      run_s1 <= 1'h0;
      run_s2 <= 1'h0;
    end else begin
      run_s1 <= LINK.card_clock_run_request_n; // R02
      run_s2 <= run_s1;
    end
  end

  // card interrupt synchroniser, line is active low and asynchronous
  always_ff @(posedge I_MCLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      int_s1 <= 1'h1;
      int_s2 <= 1'h1;
    end else begin
      int_s1 <= LINK.card_interrupt_n; // R02
      int_s2 <= int_s1;
    end
  end

  // decoded conditions
  assign card_up     = rst_q2;
  assign listen      = (notice_cnt >= SETTLE);
  // in notice, the low seen in the first cycles is still our own drive
  assign card_wants  = ~run_s2 & ((state != cbsck_pkg::CBSCK_NOTICE) | listen); // R05
  assign notice_done = (notice_cnt == NOTICE_LAST);

  // next state of the clock control
  always_comb begin
    next_state = state;
    case (state)
      cbsck_pkg::CBSCK_RUN: begin
        // slowdown starts with a notice period
        if (I_SLOW_REQ) begin
          next_state = cbsck_pkg::CBSCK_NOTICE; // R06
        end
      end
      cbsck_pkg::CBSCK_NOTICE: begin
        if (card_wants || !I_SLOW_REQ) begin
          // card objects or user changed its mind
          next_state = cbsck_pkg::CBSCK_RUN;
        end else if (notice_done) begin
          next_state = I_STOP_REQ ? cbsck_pkg::CBSCK_STOP : cbsck_pkg::CBSCK_SLOW; // R04
        end
      end
      cbsck_pkg::CBSCK_SLOW, cbsck_pkg::CBSCK_STOP: begin
        // card request restores the full rate
        if (card_wants || !I_SLOW_REQ) begin
          next_state = cbsck_pkg::CBSCK_RUN; // R05
        end
      end
      default: begin
        next_state = cbsck_pkg::CBSCK_RUN;
      end
    endcase
    // card in reset keeps the clock at full rate
    if (!card_up) begin
      next_state = cbsck_pkg::CBSCK_RUN; // R07
    end
  end

  // state register
  always_ff @(posedge I_MCLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      state <= cbsck_pkg::CBSCK_RUN;
    end else begin
      state <= next_state;
    end
  end

  // notice counter, cleared outside notice, saturates at its limit
  always_ff @(posedge I_MCLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      notice_cnt <= '0;
    end else if (state != cbsck_pkg::CBSCK_NOTICE) begin
      notice_cnt <= '0;
    end else if (!notice_done) begin
      notice_cnt <= notice_cnt + 1'b1; // R06
    end
  end

  // divider for the slowed clock
  always_ff @(posedge I_MCLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      slow_cnt <= '0;
    end else if (state != cbsck_pkg::CBSCK_SLOW || slow_cnt == SLOW_LAST) begin
      slow_cnt <= '0;
    end else begin
      slow_cnt <= slow_cnt + 1'b1;
    end
  end

  // gate request: full rate in run and notice, one pulse per divide in slow
  assign gate_req = (state == cbsck_pkg::CBSCK_STOP) ? 1'b0 :
                    (state == cbsck_pkg::CBSCK_SLOW) ? (slow_cnt == '0) :
                    1'b1; // R03

  // enable taken on the falling edge, so the gated clock never shows a
  // shortened phase: it stops after a full high and restarts with a full high
  always_ff @(negedge I_MCLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      clk_en <= `CBSCK_RST_CLK_EN;
    end else begin
      clk_en <= gate_req; // R11
    end
  end

  // gated card clock; held low whenever the enable is low
  assign LINK.card_clock = I_MCLK & clk_en; // R01 R04

  // card reset pin straight from the release stage
  assign LINK.card_reset_n = rst_q2; // R09 R10

  // clock run held low while the clock runs, released as the notice
  assign LINK.run_sock_oe = (state == cbsck_pkg::CBSCK_RUN); // R06

  // bus drive: during card reset the socket keeps the lines at valid levels;
  // otherwise user data is launched on card clock edges only
  always_ff @(posedge I_MCLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      ad_o  <= `CBSCK_RST_AD;
      ad_oe <= `CBSCK_RST_AD_OE;
    end else if (!card_up) begin
      ad_o  <= '0; // R08
      ad_oe <= 1'h1;
    end else if (clk_en) begin
      ad_o  <= I_AD_OUT; // R12
      ad_oe <= I_AD_OE;
    end
  end

  assign LINK.ad_sock_o  = ad_o;
  assign LINK.ad_sock_oe = ad_oe;

  // bus capture on each rising card clock edge; the card clock is derived
  // from the master clock, so the bus needs no synchroniser
  always_ff @(posedge I_MCLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      O_AD_IN    <= '0;
      O_AD_VALID <= 1'h0;
    end else begin
      O_AD_VALID <= clk_en & card_up;
      if (clk_en) begin
        O_AD_IN <= LINK.ad; // R02
      end
    end
  end

  // user status
  assign O_CARD_IN_RESET  = ~rst_q2;
  assign O_CARD_INTERRUPT = ~int_s2;
  assign O_CLK_STATE      = state;

endmodule

// ==== src/cbsck_card.sv ====
// card end: clock run requests, reset response and bus drive on the card clock
`timescale 1ns/1ps
`include "cbsck_consts.svh"

module cbsck_card #(
  parameter int AD_W = `CBSCK_AD_W // bus width
) (
  // link to the socket, supplies clock and reset
  cbsck_if.card                LINK,
  // card logic requests
  input  wire logic            I_NEED_CLOCK,
  input  wire logic            I_INTERRUPT,
  // card data toward the socket
  input  wire logic [AD_W-1:0] I_AD_OUT,
  input  wire logic            I_AD_OE,
  // card status and data from the socket
  output logic                 O_IN_RESET,
  output logic [AD_W-1:0]      O_AD_IN
);

  logic [AD_W-1:0] ad_o;  // value driven on the bus
  logic            ad_oe; // bus drive enable

  // pull clock run low whenever the card needs the clock and is out of reset; combinational,
  // because a stopped clock could never sample the request
  assign LINK.run_card_oe = I_NEED_CLOCK & LINK.card_reset_n; // R05 R08
  // interrupt is asynchronous, released during reset
  assign LINK.int_card_oe = I_INTERRUPT & LINK.card_reset_n; // R02 R08

  // bus drive, floated at once when reset asserts
  always_ff @(posedge LINK.card_clock or negedge LINK.card_reset_n) begin
    if (!LINK.card_reset_n) begin
      ad_o  <= '0; // R07
      ad_oe <= 1'h0; // R08
    end else begin
      ad_o  <= I_AD_OUT; // R12
      ad_oe <= I_AD_OE;
    end
  end

  assign LINK.ad_card_o  = ad_o;
  assign LINK.ad_card_oe = ad_oe;

  // capture the bus on the rising card clock
  always_ff @(posedge LINK.card_clock or negedge LINK.card_reset_n) begin
    if (!LINK.card_reset_n) begin
      O_AD_IN <= '0; // R07
    end else begin
      O_AD_IN <= LINK.ad; // R02
    end
  end

  // reset level seen by card logic
  assign O_IN_RESET = ~LINK.card_reset_n;

endmodule

// ==== test/cbsck_link_checker.sv ====
// concurrent checks on the link between the socket end and the card end
`timescale 1ns/1ps
`include "cbsck_consts.svh"

module cbsck_link_checker #(
  parameter int NOTICE_CYC = `CBSCK_NOTICE_CYC // notice length in master cycles
) (
  // master clock and reset
  input  wire logic        I_MCLK,
  input  wire logic        I_ARST_N,
  // link signals
  input  wire logic        card_clock,
  input  wire logic        card_reset_n,
  input  wire logic        run_sock_oe,
  input  wire logic        run_card_oe,
  input  wire logic        int_card_oe,
  input  wire logic        ad_sock_oe,
  input  wire logic        ad_card_oe,
  input  wire logic [31:0] ad
);
  // a missing pulse must follow a full notice with the run line released
  AST_STOP_NOTICE: assert property (@(negedge I_MCLK)
    disable iff (!I_ARST_N || !card_reset_n)
    ($past(card_clock) && !card_clock) |-> !$past(run_sock_oe, NOTICE_CYC))
    else $error("card clock slowed without notice");
  // a card clock rise must coincide with a master clock rise, never a
  // shortened high phase from an enable that changed mid-phase
  AST_CLK_START: assert property (@(posedge card_clock) disable iff (!I_ARST_N)
    !I_MCLK)
    else $error("card clock started inside a master clock high phase");
  // running mode keeps a full high phase every master cycle
  AST_RUN_FULL: assert property (@(negedge I_MCLK) disable iff (!I_ARST_N)
    (run_sock_oe && $past(run_sock_oe)) |-> card_clock)
    else $error("card clock pulse missing while running");
  // the release edge of card reset is a rising card clock edge
  AST_RST_SYNC: assert property (@(negedge I_MCLK) disable iff (!I_ARST_N)
    $rose(card_reset_n) |-> card_clock)
    else $error("card reset released off the card clock");
  // card reset stays low two edges past the master reset release
  AST_RST_LEN: assert property (@(posedge I_MCLK) disable iff (!I_ARST_N)
    $rose(I_ARST_N) |-> !card_reset_n ##1 !card_reset_n ##1 card_reset_n)
    else $error("card reset release timing wrong");
  // the card lets go of every line while held in reset
  AST_CARD_FLOAT: assert property (@(posedge I_MCLK) disable iff (!I_ARST_N)
    !card_reset_n |-> !(ad_card_oe || run_card_oe || int_card_oe))
    else $error("card drives a line during reset");
  // the socket keeps the bus at a defined level during card reset
  AST_SOCK_DRIVE: assert property (@(posedge I_MCLK) disable iff (!I_ARST_N)
    (!card_reset_n && !$past(card_reset_n)) |-> (ad_sock_oe && ad == '0))
    else $error("socket leaves the bus undriven during reset");
  // a card request brings the run line back within a bounded time
  AST_WAKE_RUN: assert property (@(posedge I_MCLK) disable iff (!I_ARST_N)
    (card_reset_n && run_card_oe && !run_sock_oe) |-> ##[0:14] run_sock_oe)
    else $error("card request for clock not honoured");
  // and the card clock itself pulses again
  AST_WAKE_CLK: assert property (@(negedge I_MCLK) disable iff (!I_ARST_N)
    (card_reset_n && run_card_oe && !run_sock_oe) |-> ##[0:16] card_clock)
    else $error("stopped card clock not restarted");
endmodule

// ==== test/cardbus_socket_clock_reset_tb_top.sv ====
// self-checking bench: socket end and card end joined by the link
`timescale 1ns/1ps
`include "cbsck_consts.svh"

module cardbus_socket_clock_reset_tb_top;
  localparam int NOTICE = `CBSCK_NOTICE_CYC; // notice length for socket and checker
  // expected result: due cycle, which output, value
  typedef struct {int due; int kind; logic [31:0] exp;} cbsck_note_s;
  cbsck_note_s                notes[$];
  logic                       mclk = 1'h0;
  logic                       arst_n = 1'h0;
  logic                       rst_req = 1'h0;
  logic                       slow_req = 1'h0;
  logic                       stop_req = 1'h0;
  logic                       s_oe = 1'h0;
  logic                       c_oe = 1'h0;
  logic                       need_clk = 1'h0;
  logic                       irq = 1'h0;
  logic [31:0]                s_dout = '0;
  logic [31:0]                c_dout = '0;
  logic [31:0]                s_din, c_din;
  logic                       s_valid, s_inres, s_irq, c_inres;
  cbsck_pkg::cbsck_clk_state_e st;
  logic [31:0]                seed = 32'h0000_92f5;
  int                         cyc = 0;
  int                         pulses = 0;
  int                         n_mismatch = 0;
  int                         tests_run = 0;

  cbsck_if link_if ();
  cbsck_socket #(.NOTICE_CYC(NOTICE)) cbsck_socket_i (.I_MCLK(mclk), .I_ARST_N(arst_n),
    .I_CARD_RESET_REQ(rst_req), .I_SLOW_REQ(slow_req), .I_STOP_REQ(stop_req),
    .I_AD_OUT(s_dout), .I_AD_OE(s_oe), .O_CARD_IN_RESET(s_inres), .O_AD_IN(s_din),
    .O_AD_VALID(s_valid), .O_CARD_INTERRUPT(s_irq), .O_CLK_STATE(st), .LINK(link_if.socket));
  cbsck_card cbsck_card_i (.LINK(link_if.card), .I_NEED_CLOCK(need_clk), .I_INTERRUPT(irq),
    .I_AD_OUT(c_dout), .I_AD_OE(c_oe), .O_IN_RESET(c_inres), .O_AD_IN(c_din));
  cbsck_link_checker #(.NOTICE_CYC(NOTICE)) cbsck_link_checker_i (.I_MCLK(mclk),
    .I_ARST_N(arst_n), .card_clock(link_if.card_clock), .card_reset_n(link_if.card_reset_n),
    .run_sock_oe(link_if.run_sock_oe), .run_card_oe(link_if.run_card_oe),
    .int_card_oe(link_if.int_card_oe), .ad_sock_oe(link_if.ad_sock_oe),
    .ad_card_oe(link_if.ad_card_oe), .ad(link_if.ad));

  // master clock, 40 ns period
  always #20 mclk = ~mclk;
  // cycle count and hang guard, far above the planned run length
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 1000) begin
      n_mismatch++;
      stop_test();
    end
  end
  // card clock pulses, used to check gating and slow rate
  always @(posedge link_if.card_clock) pulses <= pulses + 1;

  // xorshift source for bus data
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // output picked by a note
  function automatic logic [31:0] seen(int k);
    case (k)
      0: seen = s_din;
      1: seen = c_din;
      2: seen = 32'(st);
      3: seen = 32'(s_inres);
      4: seen = 32'(s_irq);
      5: seen = 32'(pulses);
      6: seen = 32'(c_inres);
      default: seen = 32'(s_valid);
    endcase
  endfunction
  task automatic check(logic [31:0] got, logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: seen %h expected %h", $time, got, exp);
    end
  endtask
  // dues must be pushed in rising order, the watcher pops from the front
  task automatic note(int d, int k, logic [31:0] v);
    notes.push_back(cbsck_note_s'{cyc + d, k, v});
  endtask
  task automatic tick(int n);
    repeat (n) @(negedge mclk);
  endtask
  task automatic stop_test();
    // a note never compared hides a missing result, so it counts as one
    if (notes.size() != 0) begin
      n_mismatch++;
    end
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // watcher: outputs are settled at the falling edge
  always @(negedge mclk) begin
    while (notes.size() > 0 && notes[0].due <= cyc) begin
      check(seen(notes[0].kind), notes[0].exp);
      void'(notes.pop_front());
    end
  end

  // driver, all inputs change on the falling edge
  initial begin
    tick(12);
    arst_n = 1'h1;
    note(1, 6, 1);
    note(2, 6, 0);
    note(2, 3, 0);
    tick(6);
    note(1, 7, 1);
    // both directions, socket first then card, then nobody
    for (int i = 0; i < 17; i++) begin
      s_oe = (i < 8);
      c_oe = (i >= 8 && i < 16);
      s_dout = rnd();
      c_dout = rnd();
      note(2, i < 8 ? 1 : 0, i < 8 ? s_dout : (i < 16 ? c_dout : '0));
      tick(1);
    end
    note(8, 5, pulses + 8);
    tick(9);
    irq = 1'h1;
    note(6, 4, 1);
    tick(6);
    irq = 1'h0;
    note(6, 4, 0);
    tick(6);
    // stop after notice, then the card asks for its clock back
    slow_req = 1'h1;
    stop_req = 1'h1;
    note(1, 2, cbsck_pkg::CBSCK_NOTICE);
    note(NOTICE, 2, cbsck_pkg::CBSCK_NOTICE);
    note(NOTICE + 1, 2, cbsck_pkg::CBSCK_STOP);
    tick(NOTICE + 3);
    note(3, 5, pulses);
    tick(3);
    need_clk = 1'h1;
    note(3, 2, cbsck_pkg::CBSCK_RUN);
    tick(3);
    slow_req = 1'h0;
    need_clk = 1'h0;
    tick(4);
    // slowed clock, one pulse in four master cycles
    slow_req = 1'h1;
    stop_req = 1'h0;
    note(NOTICE + 1, 2, cbsck_pkg::CBSCK_SLOW);
    tick(NOTICE + 2);
    note(16, 5, pulses + 4);
    tick(16);
    slow_req = 1'h0;
    note(1, 2, cbsck_pkg::CBSCK_RUN);
    tick(2);
    // card objects in mid notice
    slow_req = 1'h1;
    stop_req = 1'h1;
    tick(5);
    need_clk = 1'h1;
    note(3, 2, cbsck_pkg::CBSCK_RUN);
    tick(3);
    slow_req = 1'h0;
    need_clk = 1'h0;
    tick(3);
    // card reset at a free moment, slowdown refused meanwhile
    // the card also tries every line it owns, all must stay released
    rst_req = 1'h1;
    slow_req = 1'h1;
    c_oe = 1'h1;
    need_clk = 1'h1;
    irq = 1'h1;
    note(1, 6, 1);
    note(1, 3, 1);
    note(10, 2, cbsck_pkg::CBSCK_RUN);
    note(10, 1, 0);
    note(10, 7, 0);
    note(10, 4, 0);
    tick(10);
    rst_req = 1'h0;
    slow_req = 1'h0;
    c_oe = 1'h0;
    need_clk = 1'h0;
    irq = 1'h0;
    note(1, 6, 1);
    note(2, 6, 0);
    note(2, 3, 0);
    tick(4);
    stop_test();
  end
endmodule
